/* File: src/smcc_top.sv */
// Clock source selection, dividers and module gates with APB registers
//
// Register access over APB was decided locally.
`timescale 1ns/100ps
`include "smcc_map.svh"

//--------------------------------------------------------------------
// Two-thirds frequency divider on a sampled clock level
//--------------------------------------------------------------------
module smcc_two_thirds (
  input  wire logic clock,
  input  wire logic rstn,
  input  wire logic src_level,
  output logic      div_clock
);

  logic       prev_ff;
  logic [2:0] phase_ff;
  logic       out_ff;
  logic       edge_any;
  logic       do_toggle;

  assign edge_any  = src_level ^ prev_ff;
  // Toggles at phases 0,2,3,5 give 1.5 source periods per output period
  assign do_toggle = (phase_ff == 3'd0) || (phase_ff == 3'd2) ||
                     (phase_ff == 3'd3) || (phase_ff == 3'd5);

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      prev_ff <= 1'b0;
    else
      prev_ff <= src_level;
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      phase_ff <= 3'd0;
    else if (edge_any)
      phase_ff <= (phase_ff == `SMCC_TT_LAST) ? 3'd0 : phase_ff + 3'd1;
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      out_ff <= 1'b0;
    else if (edge_any && do_toggle)
      out_ff <= ~out_ff;
  end

  assign div_clock = out_ff;

endmodule // smcc_two_thirds

//--------------------------------------------------------------------
// Step/mod fractional divider on rising edges of the 48M level
//--------------------------------------------------------------------
module smcc_frac_div (
  input  wire logic       clock,
  input  wire logic       rstn,
  input  wire logic       src_level,
  input  wire logic       enable,
  input  wire logic [6:0] step,
  input  wire logic [7:0] modulus,
  output logic            div_clock
);

  logic       prev_ff;
  logic [8:0] acc_ff;
  logic       out_ff;
  logic       rise;
  logic [8:0] sum;
  logic       wrap;

  assign rise = src_level & ~prev_ff;
  // Two toggles per output period, so the accumulator adds twice step
  assign sum  = acc_ff + {1'b0, step, 1'b0};
  assign wrap = sum >= {1'b0, modulus};

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      prev_ff <= 1'b0;
    else
      prev_ff <= src_level;
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      acc_ff <= 9'h000;
    else if (!enable)
      acc_ff <= 9'h000;
    else if (rise)
      acc_ff <= wrap ? sum - {1'b0, modulus} : sum; // R19
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      out_ff <= 1'b0;
    else if (!enable)
      out_ff <= 1'b0;
    else if (rise && wrap)
      out_ff <= ~out_ff; // R19
  end

  assign div_clock = out_ff;

endmodule // smcc_frac_div

//--------------------------------------------------------------------
// Top level
//--------------------------------------------------------------------
module smcc_top (
  input  wire logic        clock,
  input  wire logic        rstn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        internal_osc_fast,
  input  wire logic        crystal_fast_clock,
  input  wire logic        doubled_clock_48m,
  input  wire logic        internal_osc_slow,
  input  wire logic        crystal_slow_clock,
  output logic             system_clock,
  output logic             fast_root_clock,
  output logic             usb_bus_clock,
  output logic             system_timer_clock,
  output logic             audio_serial_clock,
  output logic             pdm_microphone_clock,
  output logic             slow_clock,
  output logic [7:0]       module_gate_bank_a,
  output logic [7:0]       module_gate_bank_b,
  output logic [7:0]       module_gate_bank_c
);

  //------------------------------------------------------------------
  // Registers
  //------------------------------------------------------------------
  logic [7:0] gate_a_ff;
  logic [7:0] gate_b_ff;
  logic [7:0] gate_c_ff;
  logic [7:0] sys_sel_ff;
  logic [7:0] aud_step_ff;
  logic [7:0] aud_mod_ff;
  logic [7:0] mic_step_ff;
  logic [7:0] mic_mod_ff;
  logic [7:0] fhs_hi_ff;
  logic [7:0] slow_sel_ff;
  logic [31:0] prdata_ff;
  logic        pslverr_ff;

  logic [9:0]  idx;
  logic        hit;
  logic        wr_en;
  logic        rd_setup;
  logic [7:0]  wbyte;
  logic [7:0]  nxt_rdata;
  logic [7:0]  status;

  assign idx      = paddr[11:2];
  assign wbyte    = pwdata[7:0];
  assign rd_setup = psel & ~penable;
  assign wr_en    = psel & penable & pwrite & hit & pstrb[0] &
                    (paddr[1:0] == 2'b00);
  assign pready   = 1'b1;

  always_comb
  begin
    hit       = 1'b1;
    nxt_rdata = 8'h00;
    case (idx)
      `SMCC_IDX_GATE_A:   nxt_rdata = gate_a_ff;
      `SMCC_IDX_GATE_B:   nxt_rdata = gate_b_ff;
      `SMCC_IDX_GATE_C:   nxt_rdata = gate_c_ff;
      `SMCC_IDX_SYS_SEL:  nxt_rdata = sys_sel_ff;
      `SMCC_IDX_AUD_STEP: nxt_rdata = aud_step_ff;
      `SMCC_IDX_AUD_MOD:  nxt_rdata = aud_mod_ff;
      `SMCC_IDX_MIC_STEP: nxt_rdata = mic_step_ff;
      `SMCC_IDX_MIC_MOD:  nxt_rdata = mic_mod_ff;
      `SMCC_IDX_FHS_HI:   nxt_rdata = fhs_hi_ff;
      `SMCC_IDX_SLOW_SEL: nxt_rdata = slow_sel_ff;
      `SMCC_IDX_STATUS:   nxt_rdata = status;
      default:            hit = 1'b0;
    endcase
    if (paddr[1:0] != 2'b00)
      hit = 1'b0;
  end

  // Read data and error are captured in the setup phase
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      prdata_ff <= 32'h0000_0000;
    else if (rd_setup)
      prdata_ff <= (hit && !pwrite) ? {24'h00_0000, nxt_rdata}
                                    : 32'h0000_0000;
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      pslverr_ff <= 1'b0;
    else if (rd_setup)
      pslverr_ff <= ~hit;
  end

  assign prdata  = prdata_ff;
  assign pslverr = pslverr_ff & psel & penable;

  // Module gate banks
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      gate_a_ff <= `SMCC_RST_GATE_A; // R10
      gate_b_ff <= `SMCC_RST_GATE_B;
      gate_c_ff <= `SMCC_RST_GATE_C;
    end
    else if (wr_en)
    begin
      if (idx == `SMCC_IDX_GATE_A)
        gate_a_ff <= wbyte & `SMCC_MASK_GATE_A; // R9
      if (idx == `SMCC_IDX_GATE_B)
        gate_b_ff <= wbyte & `SMCC_MASK_GATE_B; // R9
      if (idx == `SMCC_IDX_GATE_C)
        gate_c_ff <= wbyte & `SMCC_MASK_GATE_C; // R9
    end
  end

  // Source selection registers
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      sys_sel_ff  <= `SMCC_RST_SYS_SEL;
      fhs_hi_ff   <= `SMCC_RST_FHS_HI;
      slow_sel_ff <= `SMCC_RST_SLOW_SEL;
    end
    else if (wr_en)
    begin
      if (idx == `SMCC_IDX_SYS_SEL)
        sys_sel_ff <= wbyte;
      if (idx == `SMCC_IDX_FHS_HI)
        fhs_hi_ff <= wbyte;
      if (idx == `SMCC_IDX_SLOW_SEL)
        slow_sel_ff <= wbyte;
    end
  end

  // Fractional divider settings
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      aud_step_ff <= `SMCC_RST_AUD_STEP;
      aud_mod_ff  <= `SMCC_RST_AUD_MOD;
      mic_step_ff <= `SMCC_RST_MIC_STEP;
      mic_mod_ff  <= `SMCC_RST_MIC_MOD;
    end
    else if (wr_en)
    begin
      if (idx == `SMCC_IDX_AUD_STEP)
        aud_step_ff <= wbyte;
      if (idx == `SMCC_IDX_AUD_MOD)
        aud_mod_ff <= wbyte;
      if (idx == `SMCC_IDX_MIC_STEP)
        mic_step_ff <= wbyte;
      if (idx == `SMCC_IDX_MIC_MOD)
        mic_mod_ff <= wbyte;
    end
  end

  //------------------------------------------------------------------
  // Source sampling
  //------------------------------------------------------------------
  logic rc24_ff;
  logic pad24_ff;
  logic c48_ff;
  logic rc32k_ff;
  logic pad32k_ff;

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      rc24_ff   <= 1'b0;
      pad24_ff  <= 1'b0;
      c48_ff    <= 1'b0;
      rc32k_ff  <= 1'b0;
      pad32k_ff <= 1'b0;
    end
    else
    begin
      rc24_ff   <= internal_osc_fast;
      pad24_ff  <= crystal_fast_clock;
      c48_ff    <= doubled_clock_48m;
      rc32k_ff  <= internal_osc_slow;
      pad32k_ff <= crystal_slow_clock;
    end
  end

  //------------------------------------------------------------------
  // Fast root, dividers and system clock
  //------------------------------------------------------------------
  smcc_pkg::smcc_fhs_src_t fhs_src;
  smcc_pkg::smcc_sys_src_t sys_src;
  logic       fhs_level;
  logic       fhs_prev_ff;
  logic [4:0] hs_cnt_ff;
  logic       hs_div_ff;
  logic [4:0] sys_div;
  logic       clk32m;
  logic       clk16m;
  logic       sys_level;
  logic       slow_level;
  logic       aud_div;
  logic       mic_div;
  logic       mic_level;
  logic       aud_en;
  logic       mic_en;

  assign fhs_src = smcc_pkg::smcc_fhs_src_t'(
                     {fhs_hi_ff[`SMCC_FHS_HI_BIT],
                      sys_sel_ff[`SMCC_FHS_LO_BIT]}); // R4
  assign sys_src = smcc_pkg::smcc_sys_src_t'(
                     sys_sel_ff[`SMCC_SYS_SRC_HI:`SMCC_SYS_SRC_LO]);
  assign sys_div = sys_sel_ff[`SMCC_SYS_DIV_HI:0];

  always_comb
  begin
    case (fhs_src)
      smcc_pkg::fhs_src_48m:  fhs_level = c48_ff;   // R5
      smcc_pkg::fhs_src_rc24: fhs_level = rc24_ff;  // R5
      default:                fhs_level = pad24_ff; // R5
    endcase
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      fhs_prev_ff <= 1'b0;
    else
      fhs_prev_ff <= fhs_level;
  end

  // Divide by N: high for the first N/2 root edges of each N
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      hs_cnt_ff <= 5'h00;
    else if (fhs_level && !fhs_prev_ff)
      hs_cnt_ff <= (hs_cnt_ff >= sys_div - 5'h01) ? 5'h00
                                                 : hs_cnt_ff + 5'h01; // R2
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      hs_div_ff <= 1'b0;
    else
      hs_div_ff <= hs_cnt_ff < (sys_div >> 1); // R2
  end

  smcc_two_thirds u_tt_32m (
    .clock     (clock),
    .rstn      (rstn),
    .src_level (c48_ff),
    .div_clock (clk32m)
  ); // R6

  smcc_two_thirds u_tt_16m (
    .clock     (clock),
    .rstn      (rstn),
    .src_level (pad24_ff),
    .div_clock (clk16m)
  ); // R8

  always_comb
  begin
    case (sys_src)
      smcc_pkg::sys_src_rc24: sys_level = rc24_ff;   // R1
      smcc_pkg::sys_src_fhs:  sys_level = fhs_level; // R1
      smcc_pkg::sys_src_div:  sys_level = hs_div_ff; // R1
      smcc_pkg::sys_src_32m:  sys_level = clk32m;    // R1
      default:                sys_level = rc24_ff;
    endcase
  end

  //------------------------------------------------------------------
  // Audio, microphone and slow clocks
  //------------------------------------------------------------------
  assign aud_en = aud_step_ff[`SMCC_CLK_EN_BIT];
  assign mic_en = mic_step_ff[`SMCC_CLK_EN_BIT];

  smcc_frac_div u_aud (
    .clock     (clock),
    .rstn      (rstn),
    .src_level (c48_ff),
    .enable    (aud_en),
    .step      (aud_step_ff[`SMCC_STEP_HI:0]),
    .modulus   (aud_mod_ff),
    .div_clock (aud_div)
  ); // R12

  smcc_frac_div u_mic (
    .clock     (clock),
    .rstn      (rstn),
    .src_level (c48_ff),
    .enable    (mic_en),
    .step      (mic_step_ff[`SMCC_STEP_HI:0]),
    .modulus   (mic_mod_ff),
    .div_clock (mic_div)
  ); // R16

  assign slow_level = slow_sel_ff[`SMCC_SLOW_BIT] ? pad32k_ff
                                                  : rc32k_ff; // R17 R18
  assign mic_level  = slow_sel_ff[`SMCC_MIC_SRC_BIT] ? slow_level
                                                     : mic_div; // R15

  //------------------------------------------------------------------
  // Registered clock outputs
  //------------------------------------------------------------------
  logic sys_out_ff;
  logic fhs_out_ff;
  logic usb_out_ff;
  logic tmr_out_ff;
  logic aud_out_ff;
  logic mic_out_ff;
  logic slow_out_ff;

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      sys_out_ff  <= 1'b0;
      fhs_out_ff  <= 1'b0;
      usb_out_ff  <= 1'b0;
      tmr_out_ff  <= 1'b0;
      aud_out_ff  <= 1'b0;
      mic_out_ff  <= 1'b0;
      slow_out_ff <= 1'b0;
    end
    else
    begin
      sys_out_ff  <= sys_level;
      fhs_out_ff  <= fhs_level;
      usb_out_ff  <= c48_ff & gate_a_ff[`SMCC_GATE_BUS_BIT]; // R7 R9
      tmr_out_ff  <= clk16m & gate_b_ff[`SMCC_GATE_TMR_BIT]; // R8 R9
      aud_out_ff  <= aud_div & aud_en;   // R11
      mic_out_ff  <= mic_level & mic_en; // R14
      slow_out_ff <= slow_level;
    end
  end

  assign status = {2'b00, (sys_div < 5'h02), slow_out_ff, mic_out_ff,
                   aud_out_ff, fhs_out_ff, sys_out_ff};

  assign system_clock         = sys_out_ff;
  assign fast_root_clock      = fhs_out_ff;
  assign usb_bus_clock        = usb_out_ff;
  assign system_timer_clock   = tmr_out_ff;
  assign audio_serial_clock   = aud_out_ff;
  assign pdm_microphone_clock = mic_out_ff;
  assign slow_clock           = slow_out_ff;
  assign module_gate_bank_a   = gate_a_ff;
  assign module_gate_bank_b   = gate_b_ff;
  assign module_gate_bank_c   = gate_c_ff;

endmodule // smcc_top

/* File: src/smcc_map.svh */
// Register map, field positions and reset values of the clock control
//--------------------------------------------------------------------
// Summary of operation
// R1: System source field selects INTERNAL_OSC_FAST, fast root, divided root or 32M.
// R2: Divided source gives fast root frequency over the five-bit divider.
// R3: Software never programs the system divider with zero or one.
// R4: Fast root selector spans two register bits over three sources.
// R5: Fast root 00 doubled 48M, 01 INTERNAL_OSC_FAST, 1x crystal 24M.
// R6: 32M option is the doubled 48M clock times two thirds.
// R7: Bus controller clock comes straight from the doubled 48M clock.
// R8: System tick timer runs at 16M, crystal 24M times two thirds.
// R9: Three gate banks hold module enables; one runs, zero stops.
// R10: Bank A maps serial, two-wire, UART, bus, PWM, debug; reset 0x83.
// R11: Audio serial clock runs only while its enable bit is one.
// R12: Audio serial clock is 48M times seven-bit step over eight-bit mod.
// R13: Software keeps audio mod at least twice the audio step.
// R14: Microphone clock runs only while its enable bit is one.
// R15: Microphone source bit picks divider at zero, slow clock at one.
// R16: Microphone divider gives 48M times step over mod.
// R17: Slow select bit chooses internal or crystal 32 kHz source.
// R18: Slow select zero is internal oscillator, one is crystal.
// R19: Fractional dividers accumulate step, subtract mod and toggle; the code adds twice step on each 48M rise.
//--------------------------------------------------------------------
`ifndef SMCC_MAP_SVH
`define SMCC_MAP_SVH

// Register indices; byte address is four times the index
`define SMCC_IDX_GATE_A   10'h063
`define SMCC_IDX_GATE_B   10'h064
`define SMCC_IDX_GATE_C   10'h065
`define SMCC_IDX_SYS_SEL  10'h066
`define SMCC_IDX_AUD_STEP 10'h067
`define SMCC_IDX_AUD_MOD  10'h068
`define SMCC_IDX_MIC_STEP 10'h06c
`define SMCC_IDX_MIC_MOD  10'h06d
`define SMCC_IDX_FHS_HI   10'h070
`define SMCC_IDX_SLOW_SEL 10'h073
`define SMCC_IDX_STATUS   10'h074

// Reset values
`define SMCC_RST_GATE_A   8'h83
`define SMCC_RST_GATE_B   8'h00
`define SMCC_RST_GATE_C   8'h30
`define SMCC_RST_SYS_SEL  8'h06
`define SMCC_RST_AUD_STEP 8'h00
`define SMCC_RST_AUD_MOD  8'h02
`define SMCC_RST_MIC_STEP 8'h01
`define SMCC_RST_MIC_MOD  8'h02
`define SMCC_RST_FHS_HI   8'h00
`define SMCC_RST_SLOW_SEL 8'h04

// Implemented bits; reserved bits read as zero
`define SMCC_MASK_GATE_A  8'hbf
`define SMCC_MASK_GATE_B  8'h1f
`define SMCC_MASK_GATE_C  8'h37

// Field positions
`define SMCC_SYS_SRC_HI   6
`define SMCC_SYS_SRC_LO   5
`define SMCC_SYS_DIV_HI   4
`define SMCC_FHS_LO_BIT   7
`define SMCC_FHS_HI_BIT   0
`define SMCC_CLK_EN_BIT   7
`define SMCC_STEP_HI      6
`define SMCC_SLOW_BIT     0
`define SMCC_MIC_SRC_BIT  1
`define SMCC_GATE_BUS_BIT 3
`define SMCC_GATE_TMR_BIT 1

// Two-thirds divider: toggle phases out of six source transitions
`define SMCC_TT_LAST      3'd5

`endif

/* File: src/smcc_pkg.sv */
// Types shared by the clock control design
package smcc_pkg;

  typedef enum logic [1:0] {
    sys_src_rc24 = 2'b00,
    sys_src_fhs  = 2'b01,
    sys_src_div  = 2'b10,
    sys_src_32m  = 2'b11
  } smcc_sys_src_t;

  typedef enum logic [1:0] {
    fhs_src_48m  = 2'b00,
    fhs_src_rc24 = 2'b01,
    fhs_src_pad  = 2'b10,
    fhs_src_padx = 2'b11
  } smcc_fhs_src_t;

endpackage

/* File: test/smcc_checker.sv */
// Port-level assertions for the clock control block
`timescale 1ns/100ps

module smcc_checker (
  input wire logic        clock,
  input wire logic        rstn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic        pslverr,
  input wire logic        internal_osc_slow,
  input wire logic        crystal_slow_clock,
  input wire logic        usb_bus_clock,
  input wire logic        system_timer_clock,
  input wire logic        audio_serial_clock,
  input wire logic        pdm_microphone_clock,
  input wire logic        slow_clock,
  input wire logic [7:0]  module_gate_bank_a,
  input wire logic [7:0]  module_gate_bank_b,
  input wire logic [7:0]  module_gate_bank_c
);
  logic       wr;
  logic [1:0] en_ff;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  assign wr = psel && penable && pwrite && pstrb[0];

  // Shadow of the audio and microphone enable bits
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      en_ff <= 2'h0;
    else if (wr && paddr == 12'h19c)
      en_ff[0] <= pwdata[7];
    else if (wr && paddr == 12'h1b0)
      en_ff[1] <= pwdata[7];
  end

  property p_gate_a;
    wr && paddr == 12'h18c
      |=> module_gate_bank_a == ($past(pwdata[7:0]) & 8'hbf);
  endproperty
  a_gate_a: assert property (p_gate_a) else $error("gate bank a write");

  property p_gate_b;
    wr && paddr == 12'h190
      |=> module_gate_bank_b == ($past(pwdata[7:0]) & 8'h1f);
  endproperty
  a_gate_b: assert property (p_gate_b) else $error("gate bank b write");

  property p_gate_c;
    wr && paddr == 12'h194
      |=> module_gate_bank_c == ($past(pwdata[7:0]) & 8'h37);
  endproperty
  a_gate_c: assert property (p_gate_c) else $error("gate bank c write");

  property p_gate_hold;
    !(wr && paddr inside {12'h18c, 12'h190, 12'h194})
      |=> $stable(module_gate_bank_a) && $stable(module_gate_bank_b)
          && $stable(module_gate_bank_c);
  endproperty
  a_gate_hold: assert property (p_gate_hold) else $error("gate changed");

  property p_usb_off;
    !module_gate_bank_a[3] [*3] |-> !usb_bus_clock;
  endproperty
  a_usb_off: assert property (p_usb_off) else $error("bus clock ungated");

  property p_tmr_off;
    !module_gate_bank_b[1] [*3] |-> !system_timer_clock;
  endproperty
  a_tmr_off: assert property (p_tmr_off) else $error("timer ungated");

  property p_aud_off;
    !en_ff[0] [*4] |-> !audio_serial_clock;
  endproperty
  a_aud_off: assert property (p_aud_off) else $error("audio runs");

  property p_mic_off;
    !en_ff[1] [*4] |-> !pdm_microphone_clock;
  endproperty
  a_mic_off: assert property (p_mic_off) else $error("mic runs");

  property p_slow_lo;
    (!internal_osc_slow && !crystal_slow_clock) [*3] |-> !slow_clock;
  endproperty
  a_slow_lo: assert property (p_slow_lo) else $error("slow high");

  property p_slow_hi;
    (internal_osc_slow && crystal_slow_clock) [*3] |-> slow_clock;
  endproperty
  a_slow_hi: assert property (p_slow_hi) else $error("slow low");

  c_aud: cover property (en_ff[0] && $rose(audio_serial_clock));
  c_mic: cover property (en_ff[1] && $rose(pdm_microphone_clock));
  c_err: cover property (psel && penable && pslverr);
endmodule // smcc_checker

bind smcc_top smcc_checker u_chk (
  .clock(clock), .rstn(rstn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .pslverr(pslverr), .internal_osc_slow(internal_osc_slow),
  .crystal_slow_clock(crystal_slow_clock),
  .usb_bus_clock(usb_bus_clock), .system_timer_clock(system_timer_clock),
  .audio_serial_clock(audio_serial_clock),
  .pdm_microphone_clock(pdm_microphone_clock), .slow_clock(slow_clock),
  .module_gate_bank_a(module_gate_bank_a),
  .module_gate_bank_b(module_gate_bank_b),
  .module_gate_bank_c(module_gate_bank_c)
);

/* File: test/tb.sv */
// Self-checking bench for the clock control block
`timescale 1ns/100ps

module tb;
  localparam int W     = 512;
  localparam int LIMIT = 20000;

  typedef struct packed
  {
    logic [11:0] a;
    logic [7:0]  d;
    int          o;
    int          e;
  } smcc_case_t;

  logic        clock              = 1'h0;
  logic        rstn               = 1'h0;
  logic        psel               = 1'h0;
  logic        penable            = 1'h0;
  logic        pwrite             = 1'h0;
  logic [11:0] paddr              = 12'h000;
  logic [31:0] pwdata             = 32'h0;
  logic [3:0]  pstrb              = 4'h0;
  logic        internal_osc_fast  = 1'h0;
  logic        crystal_fast_clock = 1'h0;
  logic        doubled_clock_48m  = 1'h0;
  logic        internal_osc_slow  = 1'h0;
  logic        crystal_slow_clock = 1'h0;
  logic [15:0] tick               = 16'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [6:0]  outs;
  logic [7:0]  bank_a;
  logic [7:0]  bank_b;
  logic [7:0]  bank_c;
  logic [7:0]  d;
  logic [32:0] exp_q[$];
  int          err_total = 0;
  int          n_tests   = 0;
  int          cyc       = 0;

  logic [11:0] ga [3] = '{12'h18c, 12'h190, 12'h194};
  logic [7:0]  gm [3] = '{8'hbf, 8'h1f, 8'h37};
  logic [11:0] ra [10] = '{12'h18c, 12'h190, 12'h194, 12'h198, 12'h19c,
                           12'h1a0, 12'h1b0, 12'h1b4, 12'h1c0, 12'h1cc};
  logic [7:0]  rv [10] = '{8'h83, 8'h00, 8'h30, 8'h06, 8'h00,
                           8'h02, 8'h01, 8'h02, 8'h00, 8'h04};
  smcc_case_t  cases [18] = '{
    '{12'h198, 8'h24, 0, 256},
    '{12'h198, 8'h24, 1, 256},
    '{12'h198, 8'ha4, 0, 64},
    '{12'h1c0, 8'h01, 0, 128},
    '{12'h1c0, 8'h00, 1, 64},
    '{12'h198, 8'h44, 0, 64},
    '{12'h198, 8'h64, 0, 171},
    '{12'h198, 8'h04, 0, 64},
    '{12'h18c, 8'h08, 2, 256},
    '{12'h190, 8'h02, 3, 85},
    '{12'h19c, 8'h81, 4, 128},
    '{12'h1a0, 8'h04, 4, 64},
    '{12'h19c, 8'h01, 4, 0},
    '{12'h1b0, 8'h81, 5, 128},
    '{12'h1cc, 8'h06, 5, 16},
    '{12'h1cc, 8'h07, 5, 8},
    '{12'h1cc, 8'h07, 6, 8},
    '{12'h1b0, 8'h01, 5, 0}
  };

  smcc_top DUT (
    .clock(clock), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .internal_osc_fast(internal_osc_fast),
    .crystal_fast_clock(crystal_fast_clock),
    .doubled_clock_48m(doubled_clock_48m),
    .internal_osc_slow(internal_osc_slow),
    .crystal_slow_clock(crystal_slow_clock),
    .system_clock(outs[0]), .fast_root_clock(outs[1]),
    .usb_bus_clock(outs[2]), .system_timer_clock(outs[3]),
    .audio_serial_clock(outs[4]), .pdm_microphone_clock(outs[5]),
    .slow_clock(outs[6]), .module_gate_bank_a(bank_a),
    .module_gate_bank_b(bank_b), .module_gate_bank_c(bank_c)
  );

  // ------------------------------
  // Clock, sources and watchdog
  // ------------------------------
  always #50 clock = ~clock;

  always @(posedge clock)
  begin
    tick <= tick + 16'h1;
    doubled_clock_48m <= tick[0];
    crystal_fast_clock <= tick[1];
    internal_osc_fast <= tick[2];
    internal_osc_slow <= tick[4];
    crystal_slow_clock <= tick[5];
    cyc <= cyc + 1;
    if (cyc == LIMIT)
    begin
      err_total++;
      give_verdict();
    end
  end

  // ------------------------------
  // Checks and closing
  // ------------------------------
  task automatic chk_rd(input logic [32:0] e, input logic [32:0] g);
    n_tests++;
    if (g !== e)
    begin
      err_total++;
      $display("CHECK FAILED read exp %h got %h", e, g);
    end
  endtask

  task automatic chk_cnt(input int o, input int e, input int g);
    n_tests++;
    if (g > e + 1 || g + 1 < e)
    begin
      err_total++;
      $display("CHECK FAILED clock out %0d exp %0d got %0d", o, e, g);
    end
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Read results taken at the access edge
  always @(posedge clock)
  begin
    if (psel && penable && !pwrite && pready)
    begin
      if (exp_q.size() > 0)
        chk_rd(exp_q.pop_front(), {pslverr, prdata});
      else
        chk_rd(33'h0, 33'h1ffffffff);
    end
  end

  // ------------------------------
  // Drivers
  // ------------------------------
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [7:0] dv, input logic [3:0] s,
                     input logic [32:0] e);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, dv};
    pstrb <= s;
    if (!w)
      exp_q.push_back(e);
    @(posedge clock);
    penable <= 1'h1;
    @(posedge clock);
    while (pready !== 1'h1)
    begin
      @(posedge clock);
    end
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clock);
  endtask

  task automatic measure(input int o, input int e);
    logic p;
    int   c;
    c = 0;
    repeat (8) @(negedge clock);
    p = outs[o];
    repeat (W)
    begin
      @(negedge clock);
      if (outs[o] === 1'h1 && p === 1'h0)
        c++;
      p = outs[o];
    end
    chk_cnt(o, e, c);
    @(posedge clock);
  endtask

  initial
  begin
    void'($urandom(32'h7217f2b2));
    repeat (4) @(posedge clock);
    rstn <= 1'h1;
    @(posedge clock);
    for (int i = 0; i < 10; i++)
      apb(1'h0, ra[i], 8'h00, 4'h0, {25'h0, rv[i]});
    $display("test reset_values done");
    for (int i = 0; i < 3; i++)
    begin
      d = 8'($urandom);
      apb(1'h1, ga[i], d, 4'hf, 33'h0);
      apb(1'h0, ga[i], 8'h00, 4'h0, {25'h0, d & gm[i]});
    end
    apb(1'h1, 12'h194, ~d, 4'h0, 33'h0);
    apb(1'h0, 12'h194, 8'h00, 4'h0, {25'h0, d & 8'h37});
    apb(1'h0, 12'h200, 8'h00, 4'h0, {1'h1, 32'h0});
    apb(1'h0, 12'h18d, 8'h00, 4'h0, {1'h1, 32'h0});
    $display("test register_access done");
    for (int i = 0; i < 18; i++)
    begin
      apb(1'h1, cases[i].a, cases[i].d, 4'h1, 33'h0);
      measure(cases[i].o, cases[i].e);
    end
    $display("test clock_outputs done");
    give_verdict();
  end
endmodule // tb
